// file: design/pmic_config_fault_registers.sv
`timescale 1ns/1ps
`default_nettype none
module pmic_config_fault_registers
    import pmic_regs_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic                     reg_wr_en,
    input  wire logic                     reg_rd_en,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    output logic [7:0]                    reg_rdata,
    output logic                          reg_rvalid,
    input  wire fault_evt_t [NUM_CH-1:0]  fault_evt,
    input  wire logic [NUM_CH-1:0]        dvs_level,
    input  wire logic                     cold_start_evt,
    input  wire logic                     hard_shutdown_evt,
    input  wire logic [STRAP_W-1:0]       switching_rate_pin,
    input  wire logic                     switching_rate_pin_open,
    input  wire logic [STRAP_W-1:0]       soft_start_pin,
    output var  rw_bank_t                 cfg_out,
    output logic [NUM_CH-1:0]             fault_summary,
    output var  switching_rate_pin_sel_t                primary_switch_rate,
    output var  ss_sel_t                  soft_start_time,
    output logic                          strap_valid
);

    // -------------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------------
    logic [NUM_CH-1:0][FLT_W-1:0] fault_reg;
    logic [NUM_CH-1:0][FLT_W-1:0] fault_next;
    logic [NUM_CH-1:0][FLT_W-1:0] evt_masked;
    logic [NUM_CH-1:0]            dvs_reg;
    logic                         cold_flag_reg;
    logic                         shtd_flag_reg;
    logic [7:0]                   rdata_next;
    logic [7:0]                   wdata_masked;
    rw_hit_t                      rw_hit;
    st_hit_t                      st_hit;
    logic                         wr_go;
    logic                         rd_go;

    // -------------------------------------------------------------------------
    // strap capture
    // -------------------------------------------------------------------------
    strap_sampler u_strap (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .ce                      (ce),
        .switching_rate_pin      (switching_rate_pin),
        .switching_rate_pin_open (switching_rate_pin_open),
        .soft_start_pin          (soft_start_pin),
        .primary_switch_rate     (primary_switch_rate),
        .soft_start_time         (soft_start_time),
        .strap_valid             (strap_valid)
    );

    // -------------------------------------------------------------------------
    // access decode
    // -------------------------------------------------------------------------
    // byte access by 8-bit offset, one byte per strobe
    assign wr_go        = ce && reg_wr_en;
    assign rd_go        = ce && reg_rd_en;
    assign rw_hit       = rw_lookup(reg_addr);
    assign st_hit       = st_lookup(reg_addr);
    assign wdata_masked = reg_wdata & rw_hit.mask;

    // -------------------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------------------
    // only writable bits are stored, reserved bits stay zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_out <= {NUM_RW{RW_RESET}};
        end else if (wr_go && rw_hit.hit) begin
            cfg_out[rw_hit.idx] <= wdata_masked;
        end
    end

    // -------------------------------------------------------------------------
    // per-regulator fault capture
    // -------------------------------------------------------------------------
    // channel seven only reports under- and over-voltage
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            evt_masked[c] = fault_evt[c] & ((c == CH_UV_OV_ONLY) ? FLT_MASK_UV_OV
                                                                  : FLT_MASK_FULL);
        end
    end

    // read of a status register clears its fault flags; a new event in that cycle wins
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            fault_next[c] = fault_reg[c];
            if (rd_go && st_hit.hit && st_hit.ch == c[2:0]) begin
                fault_next[c] = '0;
            end
            fault_next[c] = fault_next[c] | evt_masked[c];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_reg <= '0;
        end else if (ce) begin
            fault_reg <= fault_next;
        end
    end

    // summary flag per regulator follows its sticky fault bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fault_summary <= '0;
        end else if (ce) begin
            for (int c = 0; c < NUM_CH; c++) begin
                fault_summary[c] <= |fault_next[c];
            end
        end
    end

    // dvs level status registered for a stable read value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dvs_reg <= '0;
        end else if (ce) begin
            dvs_reg <= dvs_level;
        end
    end

    // -------------------------------------------------------------------------
    // power event flags
    // -------------------------------------------------------------------------
    // host may write the flags; a hardware event in the same cycle wins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cold_flag_reg <= 1'b0;
            shtd_flag_reg <= 1'b0;
        end else if (ce) begin
            if (wr_go && reg_addr == ADDR_POWER_EVENT) begin
                cold_flag_reg <= reg_wdata[COLDF_BIT] | cold_start_evt;
                shtd_flag_reg <= reg_wdata[SHTD_BIT] | hard_shutdown_evt;
            end else begin
                cold_flag_reg <= cold_flag_reg | cold_start_evt;
                shtd_flag_reg <= shtd_flag_reg | hard_shutdown_evt;
            end
        end
    end

    // -------------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------------
    // unmapped and reserved offsets read as zero
    always_comb begin
        rdata_next = 8'h00;
        if (rw_hit.hit) begin
            rdata_next = cfg_out[rw_hit.idx];
        end else if (st_hit.hit) begin
            rdata_next[FLT_LSB +: FLT_W] = fault_reg[st_hit.ch];
            rdata_next[DVS_BIT]          = dvs_reg[st_hit.ch];
        end else if (reg_addr == ADDR_FAULT_SUMMARY) begin
            rdata_next = fault_summary;
        end else if (reg_addr == ADDR_POWER_EVENT) begin
            rdata_next[SSTIME_LSB +: 2] = soft_start_time;
            rdata_next[COLDF_BIT]       = cold_flag_reg;
            rdata_next[SHTD_BIT]        = shtd_flag_reg;
        end
    end

    // read data returned one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= rd_go;
            if (rd_go) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_write_rw;
        wr_go && rw_hit.hit;
    endsequence

    sequence s_read_status;
        rd_go && st_hit.hit && !(|evt_masked[st_hit.ch]);
    endsequence

    sequence s_read_summary;
        rd_go && reg_addr == ADDR_FAULT_SUMMARY;
    endsequence

    fault_capture_a: assert property (
        ce && |evt_masked |=> (fault_reg & $past(evt_masked)) == $past(evt_masked))
        else $error("fault event not captured");

    clear_on_read_a: assert property (
        s_read_status |=> fault_reg[$past(st_hit.ch)] == '0)
        else $error("status read did not clear flags");

    status_read_a: assert property (
        rd_go && st_hit.hit |=> reg_rvalid
            && reg_rdata[FLT_LSB +: FLT_W] == $past(fault_reg[st_hit.ch]))
        else $error("status read data wrong");

    summary_read_a: assert property (
        s_read_summary |=> reg_rvalid && reg_rdata == $past(fault_summary))
        else $error("summary read data wrong");

    summary_track_a: assert property (
        ce && |evt_masked[0] |=> fault_summary[0] ##1 (fault_summary[0] || !ce || rd_go
            || $past(rd_go)))
        else $error("summary flag missing for channel one");

    rw_write_a: assert property (
        s_write_rw |=> cfg_out[$past(rw_hit.idx)] == $past(wdata_masked))
        else $error("configuration write not stored");

    sstime_read_a: assert property (
        rd_go && reg_addr == ADDR_POWER_EVENT
            |=> reg_rdata[SSTIME_LSB +: 2] == $past(soft_start_time))
        else $error("soft start field wrong");

    unmapped_read_a: assert property (
        rd_go && !rw_hit.hit && !st_hit.hit && reg_addr != ADDR_FAULT_SUMMARY
            && reg_addr != ADDR_POWER_EVENT |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    rvalid_pulse_a: assert property (
        ce && !reg_rd_en |=> !reg_rvalid)
        else $error("read valid without strobe");

    event_flag_a: assert property (
        ce && cold_start_evt |=> cold_flag_reg)
        else $error("cold start flag lost");

endmodule
`default_nettype wire

// file: design/pmic_regs_pkg.sv
package pmic_regs_pkg;

    // -------------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0] ADDR_RESERVED_ZERO   = 8'h00;
    localparam logic [7:0] ADDR_SHUTDOWN_SEQ    = 8'h01;
    localparam logic [7:0] ADDR_OUTPUT_ENABLE   = 8'h02;
    localparam logic [7:0] ADDR_POWER_EVENT     = 8'h03;
    localparam logic [7:0] ADDR_GATE_SETTING    = 8'h04;
    localparam logic [7:0] ADDR_GATE_FAULT      = 8'h05;
    localparam logic [7:0] ADDR_CH2_SETTING     = 8'h06;
    localparam logic [7:0] ADDR_CH2_FAULT       = 8'h07;
    localparam logic [7:0] ADDR_CH3_SETTING     = 8'h08;
    localparam logic [7:0] ADDR_CH3_FAULT       = 8'h09;
    localparam logic [7:0] ADDR_CH4_SETTING     = 8'h0a;
    localparam logic [7:0] ADDR_CH4_FAULT       = 8'h0b;
    localparam logic [7:0] ADDR_CH5_SETTING     = 8'h0c;
    localparam logic [7:0] ADDR_CH5_SOFT_START  = 8'h0d;
    localparam logic [7:0] ADDR_CH5_FAULT       = 8'h0e;
    localparam logic [7:0] ADDR_CH6_SETTING     = 8'h0f;
    localparam logic [7:0] ADDR_CH6_SOFT_START  = 8'h10;
    localparam logic [7:0] ADDR_CH6_FAULT       = 8'h11;
    localparam logic [7:0] ADDR_CH7_SETTING     = 8'h12;
    localparam logic [7:0] ADDR_CH7_SWITCHING_RATE_PIN_SS     = 8'h13;
    localparam logic [7:0] ADDR_CH7_FAULT       = 8'h14;
    localparam logic [7:0] ADDR_CH8_SETTING     = 8'h15;
    localparam logic [7:0] ADDR_CH8_MODE        = 8'h16;
    localparam logic [7:0] ADDR_CH8_FAULT       = 8'h17;
    localparam logic [7:0] ADDR_FAULT_SUMMARY   = 8'h18;
    localparam logic [7:0] ADDR_BUS_MODE        = 8'h19;
    localparam logic [7:0] ADDR_CH3_FINE_REF    = 8'h49;
    localparam logic [7:0] ADDR_CH7_DIRECT_CTRL = 8'h58;
    localparam logic [7:0] ADDR_CH7_FINE_REF    = 8'h59;

    // -------------------------------------------------------------------------
    // field layout and reset values
    // -------------------------------------------------------------------------
    localparam int         NUM_CH         = 8;
    localparam int         NUM_RW         = 18;
    localparam int         FLT_W          = 5;
    localparam int         FLT_LSB        = 1;
    localparam int         DVS_BIT        = 0;
    localparam int         SSTIME_LSB     = 0;
    localparam int         COLDF_BIT      = 3;
    localparam int         SHTD_BIT       = 4;
    localparam logic [7:0] RW_RESET       = 8'h00;
    localparam logic [4:0] FLT_MASK_FULL  = 5'h1f;
    localparam logic [4:0] FLT_MASK_UV_OV = 5'h03;
    localparam int         CH_UV_OV_ONLY  = 6;

    // -------------------------------------------------------------------------
    // strap decode thresholds, in 32nds of the internal rail
    // -------------------------------------------------------------------------
    localparam int         STRAP_W   = 6;
    localparam logic [5:0] FSW_T1000 = 6'h09;
    localparam logic [5:0] FSW_T1250 = 6'h0d;
    localparam logic [5:0] FSW_T1500 = 6'h11;
    localparam logic [5:0] FSW_T1750 = 6'h15;
    localparam logic [5:0] STRAP_FULL = 6'h20;
    localparam logic [5:0] SS_T2MS   = 6'h0b;
    localparam logic [5:0] SS_T8MS   = 6'h13;

    // -------------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        FSW_750  = 3'h0,
        FSW_1000 = 3'h1,
        FSW_1250 = 3'h2,
        FSW_1500 = 3'h3,
        FSW_1750 = 3'h4,
        FSW_2000 = 3'h5
    } switching_rate_pin_sel_t;

    typedef enum logic [1:0] {
        SS_0P5MS = 2'h0,
        SS_2MS   = 2'h1,
        SS_8MS   = 2'h2,
        SS_32MS  = 2'h3
    } ss_sel_t;

    typedef struct packed {
        logic tsd;
        logic sc;
        logic ilim;
        logic uv;
        logic ov;
    } fault_evt_t;

    typedef logic [NUM_RW-1:0][7:0] rw_bank_t;

    typedef struct packed {
        logic       hit;
        logic [4:0] idx;
        logic [7:0] mask;
    } rw_hit_t;

    typedef struct packed {
        logic       hit;
        logic [2:0] ch;
    } st_hit_t;

    // -------------------------------------------------------------------------
    // decode functions
    // -------------------------------------------------------------------------
    function automatic rw_hit_t rw_lookup(input logic [7:0] a);
        rw_hit_t r;
        r = '{hit: 1'b1, idx: 5'h00, mask: 8'h1f};
        case (a)
            ADDR_SHUTDOWN_SEQ:    r.idx = 5'h00;
            ADDR_OUTPUT_ENABLE:   begin r.idx = 5'h01; r.mask = 8'h3f; end
            ADDR_GATE_SETTING:    r.idx = 5'h02;
            ADDR_CH2_SETTING:     r.idx = 5'h03;
            ADDR_CH3_SETTING:     r.idx = 5'h04;
            ADDR_CH4_SETTING:     r.idx = 5'h05;
            ADDR_CH5_SETTING:     r.idx = 5'h06;
            ADDR_CH5_SOFT_START:  begin r.idx = 5'h07; r.mask = 8'h03; end
            ADDR_CH6_SETTING:     r.idx = 5'h08;
            ADDR_CH6_SOFT_START:  begin r.idx = 5'h09; r.mask = 8'h03; end
            ADDR_CH7_SETTING:     r.idx = 5'h0a;
            ADDR_CH7_SWITCHING_RATE_PIN_SS:     begin r.idx = 5'h0b; r.mask = 8'h0f; end
            ADDR_CH8_SETTING:     r.idx = 5'h0c;
            ADDR_CH8_MODE:        begin r.idx = 5'h0d; r.mask = 8'h7f; end
            ADDR_BUS_MODE:        begin r.idx = 5'h0e; r.mask = 8'h01; end
            ADDR_CH3_FINE_REF:    begin r.idx = 5'h0f; r.mask = 8'hff; end
            ADDR_CH7_DIRECT_CTRL: begin r.idx = 5'h10; r.mask = 8'hd0; end
            ADDR_CH7_FINE_REF:    begin r.idx = 5'h11; r.mask = 8'hff; end
            default:              begin r.hit = 1'b0; r.mask = 8'h00; end
        endcase
        return r;
    endfunction

    function automatic st_hit_t st_lookup(input logic [7:0] a);
        st_hit_t r;
        r = '{hit: 1'b1, ch: 3'h0};
        case (a)
            ADDR_GATE_FAULT: r.ch = 3'h0;
            ADDR_CH2_FAULT:  r.ch = 3'h1;
            ADDR_CH3_FAULT:  r.ch = 3'h2;
            ADDR_CH4_FAULT:  r.ch = 3'h3;
            ADDR_CH5_FAULT:  r.ch = 3'h4;
            ADDR_CH6_FAULT:  r.ch = 3'h5;
            ADDR_CH7_FAULT:  r.ch = 3'h6;
            ADDR_CH8_FAULT:  r.ch = 3'h7;
            default:         r.hit = 1'b0;
        endcase
        return r;
    endfunction

    function automatic switching_rate_pin_sel_t fsw_decode(input logic [5:0] code);
        if (code >= STRAP_FULL)     return FSW_2000;
        else if (code >= FSW_T1750) return FSW_1750;
        else if (code >= FSW_T1500) return FSW_1500;
        else if (code >= FSW_T1250) return FSW_1250;
        else if (code >= FSW_T1000) return FSW_1000;
        else                        return FSW_750;
    endfunction

    function automatic ss_sel_t ss_decode(input logic [5:0] code);
        if (code >= STRAP_FULL)   return SS_32MS;
        else if (code >= SS_T8MS) return SS_8MS;
        else if (code >= SS_T2MS) return SS_2MS;
        else                      return SS_0P5MS;
    endfunction

endpackage

// file: design/strap_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module strap_sampler
    import pmic_regs_pkg::*;
(
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic [STRAP_W-1:0] switching_rate_pin,
    input  wire logic               switching_rate_pin_open,
    input  wire logic [STRAP_W-1:0] soft_start_pin,
    output var  switching_rate_pin_sel_t          primary_switch_rate,
    output var  ss_sel_t            soft_start_time,
    output logic                    strap_valid
);

    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_HELD = 2'b10
    } strap_state_t;

    strap_state_t state_reg;

    // -------------------------------------------------------------------------
    // one-shot capture after reset release
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_WAIT;
        end else if (ce) begin
            case (state_reg)
                ST_WAIT: state_reg <= ST_HELD;
                ST_HELD: state_reg <= ST_HELD; // held until next power-up
                default: state_reg <= ST_WAIT;
            endcase
        end
    end

    // decoded values latched once, later pin changes ignored
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            primary_switch_rate <= FSW_750;
            soft_start_time     <= SS_0P5MS;
            strap_valid         <= 1'b0;
        end else if (ce && state_reg == ST_WAIT) begin
            // open pin starts at the lowest rate
            primary_switch_rate <= switching_rate_pin_open ? FSW_750
                                 : fsw_decode(switching_rate_pin);
            soft_start_time     <= ss_decode(soft_start_pin);
            strap_valid         <= 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_capture;
        ce && state_reg == ST_WAIT && !switching_rate_pin_open;
    endsequence

    strap_decode_a: assert property (
        s_capture |=> primary_switch_rate == fsw_decode($past(switching_rate_pin))
                      && soft_start_time == ss_decode($past(soft_start_pin)) && strap_valid)
        else $error("strap decode mismatch");

    strap_open_a: assert property (
        ce && state_reg == ST_WAIT && switching_rate_pin_open |=> primary_switch_rate == FSW_750)
        else $error("open pin did not give lowest rate");

    strap_hold_a: assert property (
        strap_valid |=> $stable(primary_switch_rate) && $stable(soft_start_time) && strap_valid)
        else $error("strap value changed after capture");

endmodule
`default_nettype wire

// file: dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// host master: single-byte register writes and reads
// --------------------------------------------------------------
module host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic            reg_wr_en = 1'b0,
    output logic            reg_rd_en = 1'b0,
    output logic [7:0]      reg_addr = 8'h00,
    output logic [7:0]      reg_wdata = 8'h00
);
    logic [7:0] rd_byte;
    logic       rd_ok;
    // one write strobe; released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // one read strobe, then a bounded wait for the answer
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge sys_clk);
        rd_ok = (reg_rvalid === 1'b1);
        rd_byte = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pmic_regs_pkg::*;
;
    logic       sys_clk, rst, ce, reg_wr_en, reg_rd_en, reg_rvalid, strap_valid, sw_open;
    logic       cold_start_evt, hard_shutdown_evt;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fault_summary, dvs_level, wdat[18];
    logic [5:0] f, s, sw_pin, ss_pin;
    logic [4:0] ev;
    switching_rate_pin_sel_t  rate;
    ss_sel_t    sst;
    rw_bank_t   cfg;
    int         bad_count = 0, check_count = 0, seed = 32'hb9a0b15a;
    fault_evt_t [NUM_CH-1:0] fault_evt;
    logic [7:0] rwtab[18] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0d, 8'h0f,
                              8'h10, 8'h12, 8'h13, 8'h15, 8'h16, 8'h19, 8'h49, 8'h58, 8'h59};
    logic [7:0] mtab[18] = '{8'h1f, 8'h3f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h03, 8'h1f,
                             8'h03, 8'h1f, 8'h0f, 8'h1f, 8'h7f, 8'h01, 8'hff, 8'hd0, 8'hff};
    logic [7:0] sttab[8] = '{8'h05, 8'h07, 8'h09, 8'h0b, 8'h0e, 8'h11, 8'h14, 8'h17};
    logic [7:0] rotab[4] = '{8'h00, 8'h05, 8'h18, 8'h30};
    logic [5:0] ftab[11] = '{6'h00, 6'h08, 6'h09, 6'h0c, 6'h0d, 6'h10, 6'h11, 6'h14, 6'h15,
                             6'h1f, 6'h20};
    logic [5:0] stab[11] = '{6'h00, 6'h0a, 6'h0b, 6'h12, 6'h13, 6'h1f, 6'h20, 6'h05, 6'h0c,
                             6'h14, 6'h0b};

    pmic_config_fault_registers dut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .fault_evt(fault_evt), .dvs_level(dvs_level),
        .cold_start_evt(cold_start_evt), .hard_shutdown_evt(hard_shutdown_evt),
        .switching_rate_pin(sw_pin), .switching_rate_pin_open(sw_open),
        .soft_start_pin(ss_pin), .cfg_out(cfg), .fault_summary(fault_summary),
        .primary_switch_rate(rate), .soft_start_time(sst), .strap_valid(strap_valid));
    host_model host (
        .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // --------------------------------------------------------------
    // expectations and reporting
    // --------------------------------------------------------------
    function automatic switching_rate_pin_sel_t exp_fsw(input logic [5:0] c, input logic o);
        return (o || c < 9) ? FSW_750 : c < 13 ? FSW_1000 : c < 17 ? FSW_1250 :
               c < 21 ? FSW_1500 : c < 32 ? FSW_1750 : FSW_2000;
    endfunction
    function automatic ss_sel_t exp_ss(input logic [5:0] c);
        return c < 11 ? SS_0P5MS : c < 19 ? SS_2MS : c < 32 ? SS_8MS : SS_32MS;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] e);
        check_count++;
        if (seen !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // read one register; a missing answer ends the run
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a);
        if (!host.rd_ok) begin
            bad_count++;
            finish_test();
        end else begin
            check($sformatf("reg_%h", a), host.rd_byte, e);
        end
    endtask
    // power-up with given straps, then move the pins and expect no change
    task automatic power_up(input logic [5:0] pf, input logic po, input logic [5:0] ps);
        @(negedge sys_clk);
        rst = 1'b1;
        sw_pin = pf;
        sw_open = po;
        ss_pin = ps;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("strap_valid", 8'(strap_valid), 8'h01);
        check("rate", 8'(rate), 8'(exp_fsw(pf, po)));
        check("soft_start", 8'(sst), 8'(exp_ss(ps)));
        sw_pin = ~pf;
        sw_open = ~po;
        ss_pin = ~ps;
        repeat (3) @(negedge sys_clk);
        check("rate_held", 8'(rate), 8'(exp_fsw(pf, po)));
        check("ss_held", 8'(sst), 8'(exp_ss(ps)));
    endtask

    // --------------------------------------------------------------
    // clock, watchdog and main sequence
    // --------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        finish_test();
    end
    initial begin
        {rst, ce, cold_start_evt, hard_shutdown_evt, sw_open} = 5'b11000;
        {sw_pin, ss_pin, dvs_level, fault_evt} = '0;
        for (int i = 0; i < 13; i++) begin
            f = (i < 11) ? ftab[i] : 6'($unsigned($random(seed)) % 33);
            s = (i < 11) ? stab[i] : 6'($unsigned($random(seed)) % 33);
            power_up(f, i == 10, s);
        end
        power_up(6'h0d, 1'b0, 6'h13);
        $display("test straps done");
        foreach (rwtab[i]) rd_chk(rwtab[i], 8'h00);
        foreach (rwtab[i]) begin
            wdat[i] = 8'($random(seed));
            host.wr(rwtab[i], wdat[i]);
        end
        foreach (rwtab[i]) begin
            rd_chk(rwtab[i], wdat[i] & mtab[i]);
            check("cfg_out", cfg[i], wdat[i] & mtab[i]);
        end
        foreach (rotab[i]) begin
            host.wr(rotab[i], 8'hff);
            rd_chk(rotab[i], 8'h00);
        end
        rd_chk(8'h03, 8'h02);
        @(negedge sys_clk);
        {cold_start_evt, hard_shutdown_evt} = 2'b11;
        @(negedge sys_clk);
        {cold_start_evt, hard_shutdown_evt} = 2'b00;
        rd_chk(8'h03, 8'h1a);
        host.wr(8'h03, 8'h00);
        rd_chk(8'h03, 8'h02);
        $display("test registers done");
        for (int c = 0; c < NUM_CH; c++) begin
            dvs_level = 8'($random(seed));
            ev = 5'($random(seed)) | 5'h01;
            fault_evt[c] = ev;
            @(negedge sys_clk);
            fault_evt = '0;
            @(negedge sys_clk);
            check("summary_out", fault_summary, 8'h01 << c);
            rd_chk(8'h18, 8'h01 << c);
            rd_chk(sttab[c], {2'b00, ev & ((c == 6) ? 5'h03 : 5'h1f), dvs_level[c]});
            rd_chk(sttab[c], {7'h00, dvs_level[c]});
            rd_chk(8'h18, 8'h00);
        end
        // an event while the clock enable is low must leave no trace
        @(negedge sys_clk);
        ce = 1'b0;
        fault_evt[1] = 5'h01;
        @(negedge sys_clk);
        ce = 1'b1;
        fault_evt = '0;
        @(negedge sys_clk);
        check("ce_freeze", fault_summary, 8'h00);
        $display("test fault_summary done");
        finish_test();
    end
endmodule
`default_nettype wire
